// file: design/gpcrt_regs.vh
`ifndef GPCRT_REGS_VH
`define GPCRT_REGS_VH
// register indexes (pack configuration at subclass 64, offset 0)
`define GPCRT_SUBCLASS        8'h40
`define GPCRT_A_PACKCFG       4'h0
`define GPCRT_A_ESCALE        4'h1
`define GPCRT_A_LEARN         4'h2
`define GPCRT_A_QUIT_I        4'h3
`define GPCRT_A_DSG_RELAX     4'h4
`define GPCRT_A_CHG_RELAX     4'h5
`define GPCRT_A_QUIT_RELAX    4'h6
`define GPCRT_A_STATUS        4'h7
`define GPCRT_A_AVG_I_LAST    4'h8
`define GPCRT_A_AVG_P_LAST    4'h9
`define GPCRT_A_DELTA_V       4'hA
`define GPCRT_A_RES_IDX       4'hB
`define GPCRT_A_RES_VAL       4'hC
`define GPCRT_A_RESERVE       4'hD
`define GPCRT_A_SUBCLASS      4'hE
// pack configuration: reset value and writable mask (reserved bits zero)
`define GPCRT_PACKCFG_RST     16'h0171
`define GPCRT_PACKCFG_MASK    16'hCFF1
`define GPCRT_B_NOLOAD_RESERVE_COMP        15
`define GPCRT_B_CALIB_PERMIT         14
`define GPCRT_B_VSEL          11
`define GPCRT_B_CURRENT_WAKE_ENABLE         10
`define GPCRT_B_RSNSH         9
`define GPCRT_B_RSNSL         8
`define GPCRT_B_X10           7
`define GPCRT_B_RFSTEP        6
`define GPCRT_B_SLEEP         5
`define GPCRT_B_REMAINING_FROM_FULL         4
`define GPCRT_B_THERMISTOR_SELECT         0
// energy scale
`define GPCRT_ESCALE_1        8'h01
`define GPCRT_ESCALE_10       8'h0A
// learning status codes
`define GPCRT_LS_LEARNED_OFF  8'h02
`define GPCRT_LS_ON_NEW       8'h04
`define GPCRT_LS_ON_QMAX      8'h05
`define GPCRT_LS_ON_FULL      8'h06
// timing: one tick per second of relaxation timers
`define GPCRT_TICK_NS         1000000000
`define GPCRT_CLK_NS          10
`define GPCRT_OCV_SEC         16'h0168
`define GPCRT_SLOPE_UV_S      16'h0004
`define GPCRT_QUIT_I_RST      16'h000A
`define GPCRT_DSG_RELAX_RST   16'h003C
`define GPCRT_CHG_RELAX_RST   16'h003C
`define GPCRT_QUIT_RELAX_RST  16'h0001
`define GPCRT_RES_ENTRIES     15
// average power is reported as the mean product shifted down by this much
`define GPCRT_P_SHIFT         16
`endif

// file: design/gpcrt_core.v
// Functional notes
// - reserve energy compensation: noload_reserve_comp selects no-load rate, default clear
// - energy scale accepts only 1 or 10; other writes are refused
// - enter relax when |I| below quit current for dsg time, or above for chg time
// - after about six minutes relaxed, request an open-circuit voltage capture
// - capacity update only when relaxed and voltage slope below 4 uV/s
// - leave relax only after |I| above quit current for quit relax time
// - learning status encodes 02, 04, 05, 06
// - learning status changed only by device learning or tracking enable command
// - average current over each discharge cycle, store previous cycle's average
// - multiply current by voltage, average per discharge cycle, store previous power
// - record largest voltage drop between load spikes and normal load
// - resistance table entries updated in operation, indexed by state of charge
// - pack configuration at subclass 64 offset 0, high and low bytes
// - calib_permit allows calibration mode, default zero
// - divider_select: 1 external divider, 0 internal, default zero
// - current wake enable and sense levels default 0, 0, 1
// - resistance_factor_step steps factor to limit before disabling updates, default one
// - sleep permit allows sleep when conditions allow, default one
// - remaining_from_full loads remaining capacity from full on charge termination
// - thermistor_select picks external thermistor when set, default one
//
// Implementation choice: the plain strobed port.
`timescale 1ns/100ps
`include "gpcrt_regs.vh"
module gpcrt_core #(
	parameter TICK_CYCLES = `GPCRT_TICK_NS / `GPCRT_CLK_NS
) (
	// clock, reset, enable
	input  wire        mclk,
	input  wire        rst,
	input  wire        ce,
	// register port
	input  wire [3:0]  addr,
	input  wire [15:0] wdata,
	input  wire        wr,
	input  wire        rd,
	output reg  [15:0] rdata,
	// measurements, signed except cell_voltage, which is unsigned
	input  wire        meas_valid,
	input  wire [15:0] avg_current_report,
	input  wire [15:0] inst_current,
	input  wire [15:0] cell_voltage,
	input  wire [15:0] volt_slope,
	input  wire        load_spike,
	input  wire        charge_term,
	// learning events
	input  wire        tracking_enable_cmd,
	input  wire        qmax_learned,
	input  wire        res_learned,
	input  wire        res_update,
	input  wire [3:0]  res_soc_index,
	input  wire [15:0] res_value,
	// configuration and status outputs
	output reg         noload_reserve_comp,
	output reg         calib_permit,
	output reg         divider_select,
	output reg         current_wake_enable,
	output reg         wake_sense_level_hi,
	output reg         wake_sense_level_lo,
	output reg         times_ten_units,
	output reg         resistance_factor_step,
	output reg         sleep_permit,
	output reg         remaining_from_full,
	output reg         thermistor_select,
	output reg         load_full_to_remaining,
	output reg         relax_mode,
	output reg         ocv_capture,
	output reg         qmax_update
);
	localparam [3:0] ST_FLOW  = 4'h1;
	localparam [3:0] ST_RELAX = 4'h2;
	localparam [3:0] ST_EXIT  = 4'h4;
	localparam [3:0] ST_HOLD  = 4'h8;
	localparam [31:0] TICK_MAX = TICK_CYCLES - 1;

	reg [15:0] pack_configuration;
	reg [7:0]  energy_scale;
	reg [7:0]  learning_status;
	reg [15:0] quit_current;
	reg [15:0] dsg_relax_time;
	reg [15:0] chg_relax_time;
	reg [15:0] quit_relax_time;
	reg [15:0] reserve_energy;
	reg [15:0] avg_i_last;
	reg [15:0] avg_p_last;
	reg [15:0] delta_v;
	reg [3:0]  res_sel;
	reg [15:0] res_table [0:`GPCRT_RES_ENTRIES];
	reg [3:0]  state;
	reg [31:0] tick_cnt;
	reg [15:0] below_sec;
	reg [15:0] above_sec;
	reg [15:0] relax_sec;
	reg        ocv_done;
	reg        in_dsg;
	reg signed [47:0] i_sum;
	reg signed [63:0] p_sum;
	reg [23:0] n_samp;
	reg [15:0] normal_v;

	wire        tick = (tick_cnt == TICK_MAX);
	wire [15:0] abs_i = avg_current_report[15] ? (~avg_current_report + 16'h0001) : avg_current_report;
	wire [15:0] abs_q = quit_current[15] ? (~quit_current + 16'h0001) : quit_current;
	wire        is_below = abs_i < abs_q;
	wire        is_above = abs_i > abs_q;
	wire        dsg_now = avg_current_report[15] & ~is_below;
	// voltage is unsigned; a zero top bit keeps a high reading from turning the product negative
	// the product of a 16-bit signed and a 16-bit unsigned value always fits 32 signed bits
	wire signed [32:0] power_wide = $signed(inst_current) * $signed({1'b0, cell_voltage});
	wire signed [31:0] power_now  = power_wide[31:0];
	// quotients are only used while n_samp is nonzero, so a zero divisor never reaches a register
	wire signed [47:0] i_quot     = i_sum / $signed({24'h000000, n_samp});
	wire signed [63:0] p_quot     = p_sum / $signed({40'h0000000000, n_samp});
	wire signed [63:0] p_avg      = p_quot >>> `GPCRT_P_SHIFT;
	wire [15:0] drop_now = (normal_v > cell_voltage) ? normal_v - cell_voltage : 16'h0000;
	wire        slope_ok = (volt_slope[15] ? (~volt_slope + 16'h0001) : volt_slope) < `GPCRT_SLOPE_UV_S;
	wire [15:0] packcfg_rd = pack_configuration & `GPCRT_PACKCFG_MASK;
	// status bits let software see why a capture did or did not happen
	wire        relaxed_now = (state == ST_RELAX) || (state == ST_EXIT);
	wire        scale_ten   = (energy_scale == `GPCRT_ESCALE_10);
	wire [15:0] status_word = {9'h000, ocv_done, in_dsg, relaxed_now, slope_ok, scale_ten, 2'h0};

	// configuration bits out; all straight from flops
	always @(posedge mclk) begin
		if (rst) begin
			noload_reserve_comp    <= 1'b0;
			calib_permit           <= 1'b0;
			divider_select         <= 1'b0;
			current_wake_enable    <= 1'b0;
			wake_sense_level_hi    <= 1'b0;
			wake_sense_level_lo    <= 1'b1;
			times_ten_units        <= 1'b0;
			resistance_factor_step <= 1'b1;
			sleep_permit           <= 1'b1;
			remaining_from_full    <= 1'b1;
			thermistor_select      <= 1'b1;
		end else if (ce) begin
			noload_reserve_comp    <= packcfg_rd[`GPCRT_B_NOLOAD_RESERVE_COMP];
			calib_permit           <= packcfg_rd[`GPCRT_B_CALIB_PERMIT];
			divider_select         <= packcfg_rd[`GPCRT_B_VSEL];
			current_wake_enable    <= packcfg_rd[`GPCRT_B_CURRENT_WAKE_ENABLE];
			wake_sense_level_hi    <= packcfg_rd[`GPCRT_B_RSNSH];
			wake_sense_level_lo    <= packcfg_rd[`GPCRT_B_RSNSL];
			times_ten_units        <= packcfg_rd[`GPCRT_B_X10];
			resistance_factor_step <= packcfg_rd[`GPCRT_B_RFSTEP];
			sleep_permit           <= packcfg_rd[`GPCRT_B_SLEEP];
			remaining_from_full    <= packcfg_rd[`GPCRT_B_REMAINING_FROM_FULL];
			thermistor_select      <= packcfg_rd[`GPCRT_B_THERMISTOR_SELECT];
		end
	end

	// register writes
	always @(posedge mclk) begin
		if (rst) begin
			pack_configuration <= `GPCRT_PACKCFG_RST;
			energy_scale       <= `GPCRT_ESCALE_1;
			quit_current       <= `GPCRT_QUIT_I_RST;
			dsg_relax_time     <= `GPCRT_DSG_RELAX_RST;
			chg_relax_time     <= `GPCRT_CHG_RELAX_RST;
			quit_relax_time    <= `GPCRT_QUIT_RELAX_RST;
			reserve_energy     <= 16'h0000;
			res_sel            <= 4'h0;
		end else if (ce && wr) begin
			case (addr)
			`GPCRT_A_PACKCFG: pack_configuration <= wdata & `GPCRT_PACKCFG_MASK;
			`GPCRT_A_ESCALE: begin
				// units follow the scale; the host rescales its own values
				if (wdata[7:0] == `GPCRT_ESCALE_1 || wdata[7:0] == `GPCRT_ESCALE_10) begin
					energy_scale <= wdata[7:0];
				end
			end
			`GPCRT_A_QUIT_I:     quit_current    <= wdata;
			`GPCRT_A_DSG_RELAX:  dsg_relax_time  <= wdata;
			`GPCRT_A_CHG_RELAX:  chg_relax_time  <= wdata;
			`GPCRT_A_QUIT_RELAX: quit_relax_time <= wdata;
			`GPCRT_A_RESERVE:    reserve_energy  <= wdata;
			`GPCRT_A_RES_IDX:    res_sel         <= wdata[3:0];
			default: begin
			end
			endcase
		end
	end

	// learning status: software writes are ignored
	always @(posedge mclk) begin
		if (rst) begin
			learning_status <= `GPCRT_LS_LEARNED_OFF;
		end else if (ce) begin
			if (tracking_enable_cmd) begin
				learning_status <= `GPCRT_LS_ON_NEW;
			end else if (learning_status != `GPCRT_LS_LEARNED_OFF) begin
				// resistance may be learned in a later cycle than capacity; capacity counts once seen, resistance seen before capacity is not kept
				if (res_learned && (qmax_learned || learning_status == `GPCRT_LS_ON_QMAX)) begin
					learning_status <= `GPCRT_LS_ON_FULL;
				end else if (qmax_learned && learning_status == `GPCRT_LS_ON_NEW) begin
					learning_status <= `GPCRT_LS_ON_QMAX;
				end
			end
		end
	end

	// resistance table, one entry per state-of-charge index
	genvar gi;
	generate
		for (gi = 0; gi <= `GPCRT_RES_ENTRIES; gi = gi + 1) begin : g_res
			always @(posedge mclk) begin
				if (rst) begin
					res_table[gi] <= 16'h0000;
				end else if (ce && res_update && res_soc_index == gi) begin
					res_table[gi] <= res_value;
				end
			end
		end
	endgenerate

	// one-second tick for the relax timers
	always @(posedge mclk) begin
		if (rst) begin
			tick_cnt <= 32'h00000000;
		end else if (ce) begin
			tick_cnt <= tick ? 32'h00000000 : tick_cnt + 32'h00000001;
		end
	end

	// relaxation detector
	// counters advance only on the one-second tick, so all times are whole seconds;
	// a current change between ticks is not seen until the next tick, a deliberate
	// trade of response time against counter width
	// ST_EXIT keeps the relaxed view while the quit time runs, so a short burst
	// of current does not drop the open-circuit capture already under way
	always @(posedge mclk) begin
		if (rst) begin
			state       <= ST_FLOW;
			below_sec   <= 16'h0000;
			above_sec   <= 16'h0000;
			relax_sec   <= 16'h0000;
			relax_mode  <= 1'b0;
			ocv_capture <= 1'b0;
			qmax_update <= 1'b0;
			ocv_done    <= 1'b0;
		end else if (ce) begin
			ocv_capture <= 1'b0;
			qmax_update <= 1'b0;
			case (state)
			ST_FLOW: begin
				if (tick) begin
					below_sec <= is_below ? below_sec + 16'h0001 : 16'h0000;
					above_sec <= is_above ? above_sec + 16'h0001 : 16'h0000;
					if ((is_below && below_sec + 16'h0001 >= dsg_relax_time) ||
					    (is_above && above_sec + 16'h0001 >= chg_relax_time)) begin
						state      <= ST_RELAX;
						relax_mode <= 1'b1;
						relax_sec  <= 16'h0000;
						above_sec  <= 16'h0000;
						ocv_done   <= 1'b0;
					end
				end
			end
			ST_RELAX, ST_EXIT: begin
				if (tick) begin
					if (relax_sec != `GPCRT_OCV_SEC) begin
						relax_sec <= relax_sec + 16'h0001;
					end
					if (relax_sec + 16'h0001 == `GPCRT_OCV_SEC && !ocv_done) begin
						ocv_capture <= 1'b1;
						ocv_done    <= 1'b1;
						qmax_update <= slope_ok;
					end
					if (is_above) begin
						above_sec <= above_sec + 16'h0001;
						state     <= ST_EXIT;
						if (above_sec + 16'h0001 >= quit_relax_time) begin
							state      <= ST_FLOW;
							relax_mode <= 1'b0;
							below_sec  <= 16'h0000;
							above_sec  <= 16'h0000;
						end
					end else begin
						above_sec <= 16'h0000;
						state     <= ST_RELAX;
					end
				end
			end
			default: begin
				state      <= ST_FLOW;
				relax_mode <= 1'b0;
			end
			endcase
		end
	end

	// discharge cycle averages and spike delta
	// the averages are stored once, when the cycle ends; the divider output is ignored otherwise
	// normal_v holds the last non-spike voltage; a spike before any normal sample
	// measures against zero and cannot set a drop
	always @(posedge mclk) begin
		if (rst) begin
			in_dsg     <= 1'b0;
			i_sum      <= 48'sh000000000000;
			p_sum      <= 64'sh0000000000000000;
			n_samp     <= 24'h000000;
			avg_i_last <= 16'h0000;
			avg_p_last <= 16'h0000;
			delta_v    <= 16'h0000;
			normal_v   <= 16'h0000;
			load_full_to_remaining <= 1'b0;
		end else if (ce) begin
			load_full_to_remaining <= charge_term & remaining_from_full;
			if (meas_valid) begin
				if (!load_spike) begin
					normal_v <= cell_voltage;
				end else if (drop_now > delta_v) begin
					delta_v <= drop_now;
				end
				if (dsg_now) begin
					in_dsg <= 1'b1;
					i_sum  <= i_sum + {{32{avg_current_report[15]}}, avg_current_report};
					p_sum  <= p_sum + {{32{power_now[31]}}, power_now};
					n_samp <= n_samp + 24'h000001;
				end else if (in_dsg) begin
					in_dsg <= 1'b0;
					if (n_samp != 24'h000000) begin
						avg_i_last <= i_quot[15:0];
						avg_p_last <= p_avg[15:0];
					end
					i_sum  <= 48'sh000000000000;
					p_sum  <= 64'sh0000000000000000;
					n_samp <= 24'h000000;
				end
			end
		end
	end

	// read data one cycle after the strobe; unmapped reads zero
	always @(posedge mclk) begin
		if (rst) begin
			rdata <= 16'h0000;
		end else if (ce) begin
			rdata <= 16'h0000;
			if (rd) begin
				case (addr)
				`GPCRT_A_PACKCFG:    rdata <= packcfg_rd;
				`GPCRT_A_ESCALE:     rdata <= {8'h00, energy_scale};
				`GPCRT_A_LEARN:      rdata <= {8'h00, learning_status};
				`GPCRT_A_QUIT_I:     rdata <= quit_current;
				`GPCRT_A_DSG_RELAX:  rdata <= dsg_relax_time;
				`GPCRT_A_CHG_RELAX:  rdata <= chg_relax_time;
				`GPCRT_A_QUIT_RELAX: rdata <= quit_relax_time;
				`GPCRT_A_STATUS:     rdata <= status_word;
				`GPCRT_A_AVG_I_LAST: rdata <= avg_i_last;
				`GPCRT_A_AVG_P_LAST: rdata <= avg_p_last;
				`GPCRT_A_DELTA_V:    rdata <= delta_v;
				`GPCRT_A_RES_IDX:    rdata <= {12'h000, res_sel};
				`GPCRT_A_RES_VAL:    rdata <= res_table[res_sel];
				`GPCRT_A_RESERVE:    rdata <= reserve_energy;
				`GPCRT_A_SUBCLASS:   rdata <= {8'h00, `GPCRT_SUBCLASS};
				default:             rdata <= 16'h0000;
				endcase
			end
		end
	end
endmodule

// file: verif/gpcrt_core_chk.sv
`timescale 1ns/100ps
module gpcrt_core_chk (
	// clock and reset
	input wire        mclk,
	input wire        rst,
	// register port
	input wire [3:0]  addr,
	input wire [15:0] wdata,
	input wire        wr,
	input wire        rd,
	input wire [15:0] rdata,
	// events
	input wire        charge_term,
	input wire [15:0] volt_slope,
	// outputs
	input wire        calib_permit,
	input wire        divider_select,
	input wire        times_ten_units,
	input wire        remaining_from_full,
	input wire        thermistor_select,
	input wire        load_full_to_remaining,
	input wire        relax_mode,
	input wire        ocv_capture,
	input wire        qmax_update
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	// a lone write, so the mirror two cycles on reflects it alone
	sequence s_cfg_wr;
		wr && addr == 4'h0 ##1 !(wr && addr == 4'h0);
	endsequence
	a_cfg_defaults: assert property ($fell(rst) |-> {calib_permit, divider_select, times_ten_units, remaining_from_full, thermistor_select} == 5'h03)
		else $error("config outputs not at defaults");
	a_calib_mirror: assert property (s_cfg_wr |=> calib_permit == $past(wdata[14], 2))
		else $error("calib permit does not follow write");
	a_divider_mirror: assert property (s_cfg_wr |=> divider_select == $past(wdata[11], 2))
		else $error("divider select does not follow write");
	a_x10_mirror: assert property (s_cfg_wr |=> times_ten_units == $past(wdata[7], 2))
		else $error("times ten does not follow write");
	a_thermistor_select_mirror: assert property (s_cfg_wr |=> thermistor_select == $past(wdata[0], 2))
		else $error("thermistor select does not follow write");
	a_rsvd_zero: assert property (rd && addr == 4'h0 |=> (rdata & 16'h300E) == 16'h0000)
		else $error("reserved config bits read nonzero");
	a_scale_legal: assert property (rd && addr == 4'h1 |=> rdata == 16'h0001 || rdata == 16'h000A)
		else $error("energy scale holds illegal value");
	a_full_load: assert property (charge_term && remaining_from_full |=> load_full_to_remaining)
		else $error("no reload on charge termination");
	a_full_quiet: assert property (!charge_term |=> !load_full_to_remaining)
		else $error("reload without charge termination");
	a_qmax_gate: assert property (qmax_update |-> ocv_capture && $signed($past(volt_slope)) < 16'sh0004 && $signed($past(volt_slope)) > -16'sh0004)
		else $error("capacity update without relaxed slope");
	a_ocv_relax: assert property (ocv_capture |-> relax_mode ##1 !ocv_capture)
		else $error("ocv capture outside relax or too long");
endmodule
bind gpcrt_core gpcrt_core_chk u_chk (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
	.rdata(rdata), .charge_term(charge_term), .volt_slope(volt_slope), .calib_permit(calib_permit),
	.divider_select(divider_select), .times_ten_units(times_ten_units), .remaining_from_full(remaining_from_full),
	.thermistor_select(thermistor_select), .load_full_to_remaining(load_full_to_remaining),
	.relax_mode(relax_mode), .ocv_capture(ocv_capture), .qmax_update(qmax_update));

// file: verif/gpcrt_core_tb_top.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_fail++; $display("Error %s exp %h got %h", nm, e, g); end end
module gpcrt_core_tb_top;
	localparam TICK = 10;
	reg         mclk, rst, ce, wr, rd, meas_valid, load_spike, charge_term;
	reg         tracking_enable_cmd, qmax_learned, res_learned, res_update;
	reg  [3:0]  addr, res_soc_index;
	reg  [15:0] wdata, avg_current_report, inst_current, cell_voltage, volt_slope, res_value, d, e, m;
	wire [15:0] rdata;
	wire [10:0] cfg;
	wire        load_full_to_remaining, relax_mode, ocv_capture, qmax_update;
	integer     n_fail = 0, samples_checked = 0, i, w;
	gpcrt_core #(.TICK_CYCLES(TICK)) DUT (.mclk(mclk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .meas_valid(meas_valid), .avg_current_report(avg_current_report),
		.inst_current(inst_current), .cell_voltage(cell_voltage), .volt_slope(volt_slope), .load_spike(load_spike),
		.charge_term(charge_term), .tracking_enable_cmd(tracking_enable_cmd), .qmax_learned(qmax_learned),
		.res_learned(res_learned), .res_update(res_update), .res_soc_index(res_soc_index), .res_value(res_value),
		.noload_reserve_comp(cfg[10]), .calib_permit(cfg[9]), .divider_select(cfg[8]),
		.current_wake_enable(cfg[7]), .wake_sense_level_hi(cfg[6]), .wake_sense_level_lo(cfg[5]),
		.times_ten_units(cfg[4]), .resistance_factor_step(cfg[3]), .sleep_permit(cfg[2]),
		.remaining_from_full(cfg[1]), .thermistor_select(cfg[0]), .load_full_to_remaining(load_full_to_remaining),
		.relax_mode(relax_mode), .ocv_capture(ocv_capture), .qmax_update(qmax_update));
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	function [10:0] cfg_out(input [15:0] v);
		cfg_out = {v[15], v[14], v[11], v[10], v[9], v[8], v[7], v[6], v[5], v[4], v[0]};
	endfunction
	task wr_reg(input [3:0] a, input [15:0] v);
		@(posedge mclk); wr <= 1'b1; addr <= a; wdata <= v;
		@(posedge mclk); wr <= 1'b0;
	endtask
	task rd_chk(input [3:0] a, input [15:0] x);
		@(posedge mclk); rd <= 1'b1; addr <= a;
		@(posedge mclk); rd <= 1'b0;
		#1 `CHK("rdata", x, rdata)
	endtask
	task ev(input [2:0] v);
		@(posedge mclk); {tracking_enable_cmd, qmax_learned, res_learned} <= v;
		@(posedge mclk); {tracking_enable_cmd, qmax_learned, res_learned} <= 3'h0;
	endtask
	task sample(input [15:0] c, input [15:0] v, input s);
		@(posedge mclk); meas_valid <= 1'b1; avg_current_report <= c; inst_current <= c; cell_voltage <= v; load_spike <= s;
		@(posedge mclk); meas_valid <= 1'b0;
	endtask
	// bounded wait: sel 0 watches relax_mode, 1 watches ocv_capture
	task wait_on(input sel, input val, input integer lim);
		w = 0;
		while ((sel ? ocv_capture : relax_mode) !== val && w < lim) begin
			@(posedge mclk); #1 w++;
		end
	endtask
	task print_verdict;
		$display("checks %0d errors %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		#(50000 * 10);
		n_fail++;
		print_verdict;
	end
	initial begin
		rst = 1'b1; ce = 1'b1; wr = 1'b0; rd = 1'b0; addr = 4'h0; wdata = 16'h0000; meas_valid = 1'b0;
		avg_current_report = 16'h0000; inst_current = 16'h0000; cell_voltage = 16'h0000; volt_slope = 16'h0000;
		load_spike = 1'b0; charge_term = 1'b0; tracking_enable_cmd = 1'b0; qmax_learned = 1'b0; res_learned = 1'b0;
		res_update = 1'b0; res_soc_index = 4'h0; res_value = 16'h0000; e = 16'h0001;
		void'($urandom(91));
		repeat (16) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk); #1 `CHK("cfg", 11'h02F, cfg)
		rd_chk(4'h0, 16'h0171);
		rd_chk(4'hE, 16'h0040);
		rd_chk(4'hF, 16'h0000);
		rd_chk(4'h1, 16'h0001);
		rd_chk(4'h2, 16'h0002);
		for (i = 0; i < 24; i++) begin
			d = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : 16'($urandom);
			wr_reg(4'h0, d);
			rd_chk(4'h0, d & 16'hCFF1);
			`CHK("cfg", cfg_out(d), cfg)
		end
		// illegal scale codes must leave the last legal one in place
		for (i = 0; i < 8; i++) begin
			d = i[0] ? {8'h00, 8'($urandom)} : (i[1] ? 16'h0001 : 16'h000A);
			wr_reg(4'h1, d);
			if (d == 16'h0001 || d == 16'h000A) e = d;
			rd_chk(4'h1, e);
		end
		wr_reg(4'h2, 16'h0006);
		rd_chk(4'h2, 16'h0002);
		ev(3'h2);
		rd_chk(4'h2, 16'h0002);
		ev(3'h4);
		rd_chk(4'h2, 16'h0004);
		ev(3'h2);
		rd_chk(4'h2, 16'h0005);
		ev(3'h1);
		rd_chk(4'h2, 16'h0006);
		d = 16'($urandom);
		@(posedge mclk); {res_update, res_soc_index, res_value} <= {1'b1, 4'h3, d};
		@(posedge mclk); res_update <= 1'b0;
		wr_reg(4'hB, 16'h0003);
		rd_chk(4'hC, d);
		for (i = 0; i < 2; i++) begin
			wr_reg(4'h0, i ? 16'h0189 : 16'h0199);
			@(posedge mclk); charge_term <= 1'b1;
			@(posedge mclk); charge_term <= 1'b0;
			#1 `CHK("reload", !i[0], load_full_to_remaining)
		end
		wr_reg(4'h3, 16'h000A);
		wr_reg(4'h4, 16'h0002);
		wr_reg(4'h5, 16'h0005);
		wr_reg(4'h6, 16'h0003);
		@(posedge mclk); meas_valid <= 1'b1; avg_current_report <= 16'h0000; volt_slope <= 16'h0002;
		wait_on(1'b0, 1'b1, 4 * TICK);
		`CHK("relax", 1'b1, relax_mode)
		wait_on(1'b1, 1'b1, 370 * TICK);
		`CHK("ocv_time", 1'b1, w >= 355 * TICK)
		`CHK("qmax", 1'b1, qmax_update)
		@(posedge mclk); avg_current_report <= 16'h0064;
		repeat (2 * TICK - 2) @(posedge mclk);
		#1 `CHK("relax_hold", 1'b1, relax_mode)
		wait_on(1'b0, 1'b0, 3 * TICK + 4);
		`CHK("relax_exit", 1'b0, relax_mode)
		wait_on(1'b0, 1'b1, 7 * TICK);
		`CHK("relax_chg", 1'b1, relax_mode)
		@(posedge mclk); avg_current_report <= 16'h0000; volt_slope <= 16'h0064;
		wait_on(1'b1, 1'b1, 370 * TICK);
		`CHK("ocv", 1'b1, ocv_capture)
		`CHK("qmax_steep", 1'b0, qmax_update)
		@(posedge mclk); meas_valid <= 1'b0;
		m = 16'd200 + 16'd2 * 16'($urandom % 400);
		sample(-m, 16'h8000, 1'b0);
		sample(-m, 16'h7F00, 1'b1);
		sample(-m, 16'h8000, 1'b0);
		sample(16'h0000, 16'h8000, 1'b0);
		rd_chk(4'hA, 16'h0100);
		repeat (4) sample(-m, 16'h8000, 1'b0);
		sample(16'h0000, 16'h8000, 1'b0);
		rd_chk(4'h8, -m);
		rd_chk(4'h9, -(m >> 1));
		wr_reg(4'h8, 16'h1234);
		rd_chk(4'h8, -m);
		print_verdict;
	end
endmodule
